// ===== design/wdg_pkg.sv
package wdg_pkg;

   // special function register addresses
   localparam logic [7:0] ADDR_KEY       = 8'hA6;
   localparam logic [7:0] ADDR_CONTROL   = 8'hA7;

   // key bytes: first and second halves of each sequence
   localparam logic [7:0] KEY_FEED_FIRST  = 8'h1E;
   localparam logic [7:0] KEY_FEED_SECOND = 8'hE1;
   localparam logic [7:0] KEY_SOFT_FIRST  = 8'h5A;
   localparam logic [7:0] KEY_SOFT_SECOND = 8'hA5;

   // control register field positions
   localparam int POS_PERIOD_LO  = 5;
   localparam int POS_PERIOD_HI  = 7;
   localparam int POS_FREEZE     = 4;
   localparam int POS_SOFT_FLAG  = 2;
   localparam int POS_OVF_FLAG   = 1;
   localparam int POS_RUNNING    = 0;

   // control register value after reset (unused bit 3 reads as zero)
   localparam logic [7:0] CONTROL_RESET  = 8'h00;

   // widths of the counting chain
   localparam int PRE_W   = 7;
   localparam int MAIN_W  = 14;
   localparam int TPS_W   = 4;

   // cycles of the internal reset pulse
   localparam int PULSE_CYCLES = 1;

   // one special function register access
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } wdg_sfr_req_t;

   // control register image
   typedef struct packed {
      logic [2:0] period;
      logic       freeze_in_idle;
      logic       unused;
      logic       soft_reset_flag;
      logic       overflow_flag;
      logic       running_status;
   } wdg_ctrl_t;

   // key sequence progress, gray along idle -> feed -> soft
   typedef enum logic [1:0] {
      KEY_IDLE = 2'b00,
      KEY_FEED = 2'b01,
      KEY_SOFT = 2'b11
   } wdg_key_state_t;

endpackage

// ===== design/wdg_watchdog_unit.sv
`timescale 1ns/1ps
`default_nettype none

module wdg_watchdog_unit
   import wdg_pkg::*;
(
   input  wire logic             CORE_CLK,
   input  wire logic             RST_B,
   input  wire logic             SYS_RST,
   input  wire wdg_sfr_req_t     SFR_REQ,
   output logic      [7:0]       SFR_RDATA,
   input  wire logic [TPS_W-1:0] TIMER_PRESCALE,
   input  wire logic             IDLE_MODE,
   input  wire logic             POWER_DOWN,
   output logic                  CPU_RESET_PULSE,
   output logic                  RUNNING
);

   // mask of prescaler bits that must be all ones for a prescaler tick
   function automatic logic [PRE_W-1:0] pre_mask(input logic [2:0] code);
      logic [PRE_W:0] one_hot;
      one_hot  = '0;
      one_hot[code] = 1'b1;
      pre_mask = PRE_W'(one_hot - (PRE_W+1)'(1));
   endfunction

   // state
   wdg_key_state_t     key_r;
   wdg_key_state_t     key_nxt;
   logic [2:0]         period_r;
   logic               freeze_r;
   logic               soft_flag_r;
   logic               ovf_flag_r;
   logic               run_r;
   logic               pulse_r;
   logic [TPS_W-1:0]   tps_cnt_r;
   logic [PRE_W-1:0]   pre_cnt_r;
   logic [MAIN_W-1:0]  main_cnt_r;
   logic [7:0]         rdata_r;

   // bus decode
   wire key_wr   = SFR_REQ.wr && (SFR_REQ.addr == ADDR_KEY);
   wire ctl_wr   = SFR_REQ.wr && (SFR_REQ.addr == ADDR_CONTROL);
   wire ctl_rd   = SFR_REQ.rd && (SFR_REQ.addr == ADDR_CONTROL);
   wire other_wr = SFR_REQ.wr && !key_wr;

   // any reset of the chip other than power-on reset seen by this block, including our own pulse
   wire chip_rst = SYS_RST || pulse_r;

   // sequence outcomes, decoded combinationally from the key state
   logic feed_ok;
   logic soft_ok;
   logic bad_seq;

   // key sequence checker; reads never move it, so they may sit in the gap
   always_comb begin
      key_nxt = key_r;
      feed_ok = 1'b0;
      soft_ok = 1'b0;
      bad_seq = 1'b0;
      case (key_r)
         KEY_IDLE: begin
            if (key_wr) begin
               if (SFR_REQ.wdata == KEY_FEED_FIRST) begin
                  key_nxt = KEY_FEED;
               end else if (SFR_REQ.wdata == KEY_SOFT_FIRST) begin
                  key_nxt = KEY_SOFT;
               end else begin
                  bad_seq = 1'b1;
               end
            end
         end
         KEY_FEED: begin
            if (key_wr) begin
               key_nxt = KEY_IDLE;
               feed_ok = (SFR_REQ.wdata == KEY_FEED_SECOND);
               bad_seq = (SFR_REQ.wdata != KEY_FEED_SECOND);
            end else if (other_wr) begin
               // a write elsewhere breaks the pair
               key_nxt = KEY_IDLE;
               bad_seq = 1'b1;
            end
         end
         KEY_SOFT: begin
            if (key_wr) begin
               key_nxt = KEY_IDLE;
               soft_ok = (SFR_REQ.wdata == KEY_SOFT_SECOND);
               bad_seq = (SFR_REQ.wdata != KEY_SOFT_SECOND);
            end else if (other_wr) begin
               key_nxt = KEY_IDLE;
               bad_seq = 1'b1;
            end
         end
         default: begin
            key_nxt = KEY_IDLE;
         end
      endcase
   end

   // counting chain enables
   wire frozen    = IDLE_MODE && freeze_r;
   wire cnt_en    = run_r && !frozen && !POWER_DOWN;
   wire tps_tick  = cnt_en && (tps_cnt_r == TIMER_PRESCALE);
   wire pre_full  = (pre_cnt_r & pre_mask(period_r)) == pre_mask(period_r);
   wire pre_tick  = tps_tick && pre_full;
   wire main_full = (main_cnt_r == {MAIN_W{1'b1}});
   // a feed in the same cycle as the last tick wins over the timeout
   wire timeout   = pre_tick && main_full && !feed_ok;
   wire cnt_clr   = feed_ok || !run_r || chip_rst;

   // reset request and its cause
   wire pulse_nxt = timeout || soft_ok || bad_seq;
   wire soft_set  = soft_ok || bad_seq;
   wire ovf_set   = timeout || bad_seq;

   // control image as software sees it
   wdg_ctrl_t ctrl_view;
   assign ctrl_view.period          = period_r;
   assign ctrl_view.freeze_in_idle  = freeze_r;
   assign ctrl_view.unused          = 1'b0;
   assign ctrl_view.soft_reset_flag = soft_flag_r;
   assign ctrl_view.overflow_flag   = ovf_flag_r;
   assign ctrl_view.running_status  = run_r;

   // write-zero clears a flag; a set in the same cycle wins
   wire soft_keep = !(ctl_wr && !SFR_REQ.wdata[POS_SOFT_FLAG]);
   wire ovf_keep  = !(ctl_wr && !SFR_REQ.wdata[POS_OVF_FLAG]);

   // key sequence state
   always_ff @(posedge CORE_CLK) begin
      if (!RST_B || chip_rst) begin
         key_r <= KEY_IDLE;
      end else begin
         key_r <= key_nxt;
      end
   end

   // period and freeze fields return to zero on every reset
   always_ff @(posedge CORE_CLK) begin
      if (!RST_B || chip_rst) begin
         period_r <= CONTROL_RESET[POS_PERIOD_HI:POS_PERIOD_LO];
         freeze_r <= CONTROL_RESET[POS_FREEZE];
      end else if (ctl_wr) begin
         period_r <= SFR_REQ.wdata[POS_PERIOD_HI:POS_PERIOD_LO];
         freeze_r <= SFR_REQ.wdata[POS_FREEZE];
      end
   end

   // flags only clear on power-on reset or by software, so the cause
   // of a watchdog reset can be read back afterwards
   always_ff @(posedge CORE_CLK) begin
      if (!RST_B) begin
         soft_flag_r <= CONTROL_RESET[POS_SOFT_FLAG];
         ovf_flag_r  <= CONTROL_RESET[POS_OVF_FLAG];
      end else begin
         soft_flag_r <= soft_set || (soft_flag_r && soft_keep);
         ovf_flag_r  <= ovf_set || (ovf_flag_r && ovf_keep);
      end
   end

   // running status; control writes never reach it
   always_ff @(posedge CORE_CLK) begin
      if (!RST_B || chip_rst || POWER_DOWN) begin
         run_r <= CONTROL_RESET[POS_RUNNING];
      end else if (feed_ok) begin
         run_r <= 1'b1;
      end
   end

   // internal reset pulse, one cycle wide
   always_ff @(posedge CORE_CLK) begin
      if (!RST_B) begin
         pulse_r <= 1'b0;
      end else begin
         pulse_r <= pulse_nxt && !pulse_r;
      end
   end

   // timer prescale divider in front of the chain
   always_ff @(posedge CORE_CLK) begin
      if (!RST_B || cnt_clr) begin
         tps_cnt_r <= '0;
      end else if (cnt_en) begin
         tps_cnt_r <= tps_tick ? '0 : tps_cnt_r + TPS_W'(1);
      end
   end

   // 7-bit prescaler then 14-bit counter
   always_ff @(posedge CORE_CLK) begin
      if (!RST_B || cnt_clr) begin
         pre_cnt_r  <= '0;
         main_cnt_r <= '0;
      end else if (tps_tick) begin
         pre_cnt_r  <= pre_full ? '0 : pre_cnt_r + PRE_W'(1);
         if (pre_full) begin
            main_cnt_r <= main_cnt_r + MAIN_W'(1);
         end
      end
   end

   // read data; the key register reads as zero
   always_ff @(posedge CORE_CLK) begin
      if (!RST_B) begin
         rdata_r <= 8'h00;
      end else begin
         rdata_r <= ctl_rd ? 8'(ctrl_view) : 8'h00;
      end
   end

   assign SFR_RDATA       = rdata_r;
   assign CPU_RESET_PULSE = pulse_r;
   assign RUNNING         = run_r;

   // checks on the rules this block must keep
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RST_B);

   // timeout raises the pulse and overflow flag next cycle
   timeout_pulse_a: assert property (
      (timeout && !pulse_r) |=> CPU_RESET_PULSE && ovf_flag_r)
      else $error("timeout did not reset or flag overflow");

   // a correct enable pair starts the watchdog
   enable_pair_a: assert property (
      (key_r == KEY_FEED && key_wr && SFR_REQ.wdata == KEY_FEED_SECOND
       && !chip_rst && !POWER_DOWN) |=> RUNNING)
      else $error("enable pair did not start the watchdog");

   // a control write alone never changes running status
   run_readonly_a: assert property (
      (ctl_wr && !chip_rst && !POWER_DOWN) |=> RUNNING == $past(RUNNING))
      else $error("control write changed running status");

   // feed restarts the interval from zero
   feed_restart_a: assert property (
      feed_ok |=> (main_cnt_r == '0) && (pre_cnt_r == '0) && (tps_cnt_r == '0))
      else $error("feed did not clear the counting chain");

   // reads in the gap leave the sequence pending
   read_gap_a: assert property (
      (key_r != KEY_IDLE && !SFR_REQ.wr && !chip_rst) |=> key_r == $past(key_r))
      else $error("read disturbed key sequence");

   // wrong sequence: pulse with both flags
   bad_seq_a: assert property (
      bad_seq && !pulse_r |=> CPU_RESET_PULSE && soft_flag_r && ovf_flag_r)
      else $error("bad sequence not handled");

   // soft reset pair sets only the soft flag
   soft_pair_a: assert property (
      (soft_ok && !pulse_r) |=> CPU_RESET_PULSE && soft_flag_r
                                && ovf_flag_r == $past(ovf_flag_r))
      else $error("soft reset pair mishandled");

   // power-down disables within one cycle
   power_down_a: assert property (
      POWER_DOWN |=> !RUNNING)
      else $error("watchdog running in power-down");

   // frozen in idle: chain holds its value
   idle_freeze_a: assert property (
      (run_r && IDLE_MODE && freeze_r && !feed_ok && !chip_rst)
      |=> $stable(main_cnt_r) && $stable(pre_cnt_r))
      else $error("counter moved while frozen in idle");

   // soft flag survives the reset it causes
   flags_hold_a: assert property (
      (soft_flag_r && soft_keep) |=> soft_flag_r ##1 (soft_flag_r || !$past(soft_keep)))
      else $error("soft flag lost without software clear");

   // after the pulse the watchdog is stopped
   reset_stop_a: assert property (
      CPU_RESET_PULSE |=> !RUNNING && (main_cnt_r == '0))
      else $error("watchdog kept running after reset");

   // a main counter step only on a full prescaler window
   chain_step_a: assert property (
      (main_cnt_r != $past(main_cnt_r) && !$past(cnt_clr))
      |-> $past(pre_tick))
      else $error("main counter stepped early");

   // overflow flag survives the reset it causes
   ovf_hold_a: assert property (
      (ovf_flag_r && ovf_keep) |=> ovf_flag_r ##1 (ovf_flag_r || !$past(ovf_keep)))
      else $error("overflow flag lost without software clear");

   // software clear of the soft flag takes effect
   flag_clear_a: assert property (
      (ctl_wr && !SFR_REQ.wdata[POS_SOFT_FLAG] && !soft_set) |=> !soft_flag_r)
      else $error("soft flag not cleared by software");

   // the reset request is never longer than one cycle
   pulse_once_a: assert property (
      CPU_RESET_PULSE |=> !CPU_RESET_PULSE)
      else $error("reset pulse longer than one cycle");

   // any second key byte closes the sequence
   key_close_a: assert property (
      (key_r != KEY_IDLE && key_wr) |=> key_r == KEY_IDLE)
      else $error("key sequence left open after second byte");

   // an unknown first byte resets with both flags
   bad_first_a: assert property (
      (key_r == KEY_IDLE && key_wr && SFR_REQ.wdata != KEY_FEED_FIRST
       && SFR_REQ.wdata != KEY_SOFT_FIRST && !pulse_r)
      |=> CPU_RESET_PULSE && soft_flag_r && ovf_flag_r)
      else $error("bad first key byte not handled");

   // another chip reset stops the watchdog
   sys_reset_a: assert property (
      SYS_RST |=> !RUNNING && (main_cnt_r == '0))
      else $error("chip reset left the watchdog running");

   // a stopped watchdog holds its chain at zero
   stopped_clear_a: assert property (
      !run_r |=> (main_cnt_r == '0) && (pre_cnt_r == '0) && (tps_cnt_r == '0))
      else $error("counting chain moved while stopped");

   // idle without freeze keeps the chain counting
   idle_count_a: assert property (
      (run_r && IDLE_MODE && !freeze_r && !POWER_DOWN && !chip_rst && !feed_ok
       && tps_cnt_r != TIMER_PRESCALE) |=> tps_cnt_r != $past(tps_cnt_r))
      else $error("counter stalled in idle without freeze");

endmodule

`default_nettype wire

// ===== dv/wdg_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none

// cpu side of the sfr bus: one strobe per access, taken at a rising edge
module wdg_cpu_model
   import wdg_pkg::*;
(
   input  wire logic       clk,
   output var wdg_sfr_req_t req,
   input  wire logic [7:0] rdata
);
   initial req = '0;

   // released bus shows inverted leftovers so stale data is never trusted
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk);
      req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
   endtask

   // read data stands one cycle only, so it is taken at the next low phase
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk);
      req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge clk);
      req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hFF};
      @(negedge clk);
      d = rdata;
   endtask
endmodule

`default_nettype wire

// ===== dv/watchdog_with_software_reset_tb.sv
`timescale 1ns/1ps
`default_nettype none

module watchdog_with_software_reset_tb;
   import wdg_pkg::*;
   logic             clk;
   logic             rst_b;
   logic             sys_rst;
   logic             idle;
   logic             pdown;
   logic [TPS_W-1:0] timer_prescale;
   wdg_sfr_req_t     req;
   logic [7:0]       rdata;
   logic [7:0]       v;
   logic [7:0]       b;
   logic             pulse;
   logic             running;
   int               n_mismatch = 0;
   int               num_checks = 0;
   int               npulse = 0;
   int               ep = 0;
   int               cyc = 0;
   int               n;
   int               k;

   wdg_watchdog_unit DUT (
      .CORE_CLK        (clk),
      .RST_B           (rst_b),
      .SYS_RST         (sys_rst),
      .SFR_REQ         (req),
      .SFR_RDATA       (rdata),
      .TIMER_PRESCALE  (timer_prescale),
      .IDLE_MODE       (idle),
      .POWER_DOWN      (pdown),
      .CPU_RESET_PULSE (pulse),
      .RUNNING         (running)
   );

   wdg_cpu_model cpu (
      .clk   (clk),
      .req   (req),
      .rdata (rdata)
   );

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // pulse tally and hang guard; the longest run is well under the ceiling
   always @(posedge clk) begin
      cyc++;
      if (pulse === 1'b1) begin
         npulse++;
      end
      if (cyc == 100000) begin
         n_mismatch++;
         summarize();
      end
   end

   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      num_checks++;
      if (s !== e) begin
         n_mismatch++;
         $display("ERROR %s expected %0h seen %0h", nm, e, s);
      end
   endtask

   function automatic int period(input int ps, input int t);
      return (t + 1) << (ps + 14);
   endfunction

   // one more reset pulse is due; check the image, then software clears it
   task automatic ev(input logic [7:0] e);
      ep++;
      repeat (3) @(negedge clk);
      chk("pulses", npulse, ep);
      cpu.rd(ADDR_CONTROL, v);
      chk("ctrl", v, e);
      cpu.wr(ADDR_CONTROL, 8'h00);
   endtask

   task automatic arm();
      cpu.wr(ADDR_KEY, KEY_FEED_FIRST);
      cpu.wr(ADDR_KEY, KEY_FEED_SECOND);
      @(negedge clk);
      chk("running", running, 1'b1);
   endtask

   // window of two cycles either side absorbs the launch and pulse latency
   task automatic tmo(input int p);
      int q;
      q = npulse;
      n = 0;
      while (npulse == q && n < 70000) begin
         @(negedge clk);
         n++;
      end
      chk("timeout", (n >= p - 2 && n <= p + 2), 1'b1);
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   initial begin
      rst_b = 1'b0;
      sys_rst = 1'b0;
      idle = 1'b0;
      pdown = 1'b0;
      timer_prescale = '0;
      void'($urandom(32'h8426f9c3));
      repeat (4) @(posedge clk);
      @(negedge clk);
      rst_b = 1'b1;
      cpu.rd(ADDR_CONTROL, v);
      chk("ctrl_reset", v, CONTROL_RESET);
      b = 8'($urandom) | 8'h09; // bit 0 and bit 3 are always tried
      cpu.wr(ADDR_CONTROL, b);
      cpu.rd(ADDR_CONTROL, v);
      chk("ctrl_fields", v, b & 8'hF0);
      cpu.rd(ADDR_KEY, v);
      chk("key_read", v, 8'h00);
      cpu.rd(8'hA8, v);
      chk("unmapped", v, 8'h00);
      cpu.wr(ADDR_CONTROL, 8'h00);
      // doubled prescale in idle without freeze, harmless read between key bytes
      @(negedge clk);
      timer_prescale = TPS_W'(1);
      idle = 1'b1;
      cpu.wr(ADDR_KEY, KEY_FEED_FIRST);
      cpu.rd(ADDR_CONTROL, v);
      cpu.wr(ADDR_KEY, KEY_FEED_SECOND);
      tmo(period(0, 1));
      idle = 1'b0;
      ev(8'h02);
      // a late feed restarts the whole interval, period code one doubles it
      @(negedge clk);
      timer_prescale = '0;
      cpu.wr(ADDR_CONTROL, 8'h20);
      arm();
      repeat (3000) @(negedge clk);
      arm();
      tmo(period(1, 0));
      ev(8'h02);
      // idle with freeze set stretches the timeout by the idle time
      cpu.wr(ADDR_CONTROL, 8'h10);
      arm();
      k = 100 + $urandom % 900;
      idle = 1'b1;
      repeat (k) @(negedge clk);
      idle = 1'b0;
      tmo(period(0, 0));
      ev(8'h02);
      // software reset works with the watchdog stopped
      cpu.wr(ADDR_KEY, KEY_SOFT_FIRST);
      cpu.wr(ADDR_KEY, KEY_SOFT_SECOND);
      ev(8'h04);
      // bad first byte, bad second bytes, foreign write inside the pair
      for (int i = 0; i < 4; i++) begin
         b = KEY_FEED_FIRST;
         while (b inside {KEY_FEED_FIRST, KEY_SOFT_FIRST, KEY_FEED_SECOND, KEY_SOFT_SECOND}) begin
            b = 8'($urandom);
         end
         if (i == 1 || i == 2) begin
            cpu.wr(ADDR_KEY, (i == 1) ? KEY_FEED_FIRST : KEY_SOFT_FIRST);
         end
         if (i == 3) begin
            cpu.wr(ADDR_KEY, KEY_FEED_FIRST);
            cpu.wr(ADDR_CONTROL, 8'h00);
         end else begin
            cpu.wr(ADDR_KEY, b);
         end
         ev(8'h06);
      end
      // power-down stops a running watchdog
      arm();
      pdown = 1'b1;
      repeat (2) @(negedge clk);
      pdown = 1'b0;
      chk("pd_stop", running, 1'b0);
      // other chip reset keeps flags but stops the watchdog
      cpu.wr(ADDR_KEY, KEY_SOFT_FIRST);
      cpu.wr(ADDR_KEY, KEY_SOFT_SECOND);
      repeat (3) @(negedge clk);
      arm();
      sys_rst = 1'b1;
      @(negedge clk);
      sys_rst = 1'b0;
      ev(8'h04);
      summarize();
   end
endmodule

`default_nettype wire
